// ==== include/sec_consts.svh ====
// constants of the serial eeprom command engine
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH
`define SEC_ADDR_W        17
`define SEC_MEM_WORDS     131072
`define SEC_PAGE_WORDS    256
`define SEC_TYPE_MEM      4'ha
`define SEC_TYPE_ID       4'hb
`define SEC_HI_LOCK_BIT   2
`define SEC_LOCK_DATA_BIT 1
`define SEC_LAST_BIT      4'h7
`define SEC_ACK_BIT       4'h8
`define SEC_ADDR_LAST     17'h1_ffff
`define SEC_T_WR_NS       5000000
`define SEC_CLK_NS        4
`define SEC_WR_CYCLES     (`SEC_T_WR_NS / `SEC_CLK_NS)
`endif

// ==== include/sec_pkg.sv ====
// types of the serial eeprom command engine
package sec_pkg;
    typedef enum logic [5:0] {
        SEC_SEL  = 6'h01,
        SEC_AHI  = 6'h02,
        SEC_ALO  = 6'h04,
        SEC_WDAT = 6'h08,
        SEC_RDAT = 6'h10,
        SEC_IGN  = 6'h20
    } sec_state_t;
    typedef struct packed {
        logic [3:0] kind;
        logic [1:0] cs;
        logic       top_address_bit;
        logic       rd;
    } sec_sel_t;
endpackage : sec_pkg

// ==== core/sec_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sec_sync import sec_pkg::*; #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_reg
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end
endmodule : sec_sync
`default_nettype wire

// ==== core/sec_wtimer.sv ====
// self-timed programming cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "sec_consts.svh"
module sec_wtimer import sec_pkg::*; #(
    parameter int unsigned CYCLES = `SEC_WR_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // start pulse and busy level
    input  wire logic start,
    output logic      busy_reg
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (start && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg  <= CW'(CYCLES - 1);
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - CW'(1);
            end
        end
    end
endmodule : sec_wtimer
`default_nettype wire

// ==== core/sec_engine.sv ====
// two-wire serial eeprom target: command decode, array, id page, lock
`timescale 1ns/1ps
`default_nettype none
`include "sec_consts.svh"
module sec_engine import sec_pkg::*; #(
    parameter int unsigned WR_CYCLES = `SEC_WR_CYCLES
) (
    // system clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // two-wire link
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n,
    // straps
    input  wire logic chip_select_pin_low,
    input  wire logic chip_select_pin_high,
    input  wire logic write_inhibit,
    // status
    output logic      write_busy,
    output logic      id_locked
);
    // ==========================================================
    // reference domain: reset, pin sampling, start and stop
    logic        rst_meta_reg;
    logic        rst_n_reg;
    logic [1:0]  pin_s;
    logic [1:0]  pin_prev_reg;
    logic        start_evt;
    logic        stop_evt;
    logic        frame_clr_reg;
    logic        wr_seen_s;
    logic        wr_seen_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    sec_sync #(.W(2)) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (rst_n_reg),
        .d     ({scl, sda_i}),
        .q_reg (pin_s)
    );

    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_prev_reg <= 2'h3;
        end else begin
            pin_prev_reg <= pin_s;
        end
    end

    // both samples must see scl high, so the reset release is no false edge
    assign start_evt = pin_s[1] && pin_prev_reg[1] && pin_prev_reg[0] && !pin_s[0];
    assign stop_evt  = pin_s[1] && pin_prev_reg[1] && !pin_prev_reg[0] && pin_s[0];

    // clears the link logic from a start until scl first falls
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            frame_clr_reg <= 1'b1;
        end else if (start_evt) begin
            frame_clr_reg <= 1'b1;
        end else if (!pin_s[1]) begin
            frame_clr_reg <= 1'b0;
        end
    end

    // wr_seen is stable once scl idles high, so a level crossing suffices
    sec_sync #(.W(1)) u_wr_sync (
        .clk   (ref_clk),
        .rst_n (rst_n_reg),
        .d     (wr_seen_reg),
        .q_reg (wr_seen_s)
    );

    sec_wtimer #(.CYCLES(WR_CYCLES)) u_timer (
        .clk      (ref_clk),
        .rst_n    (rst_n_reg),
        .start    (stop_evt && wr_seen_s),
        .busy_reg (write_busy)
    );

    chk_write_timer : assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
        stop_evt && wr_seen_s && !write_busy |=> write_busy [*8])
        else $error("programming cycle did not start on write stop");

    // ==========================================================
    // link domain: straps, shifter and command decode
    logic [3:0]  strap_s;
    logic        wp_s;
    logic [1:0]  cs_s;
    logic        busy_s;
    sec_state_t  st_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic        ack_reg;
    logic        rd_first_reg;
    logic        rd_tx_reg;
    logic        is_id_reg;
    logic        id_lock_select_bit_reg;
    logic [8:0]  hi_reg;
    logic [16:0] addr_reg;
    logic        lock_reg;
    logic        oe_n_reg;
    logic [7:0]  rx_byte;
    sec_sel_t    sel;
    logic        byte_end;
    logic        ack_slot;
    logic        sel_ok;
    logic        mem_wr;
    logic        id_wr;
    logic        lock_identification_command;
    logic        rd_load;
    logic [16:0] page_next;
    logic [7:0]  mem [`SEC_MEM_WORDS];
    logic [7:0]  id_mem [`SEC_PAGE_WORDS];

    function automatic logic [16:0] page_inc(input logic [16:0] a);
        page_inc = {a[16:8], a[7:0] + 8'h01};
    endfunction : page_inc

    sec_sync #(.W(4)) u_strap_sync (
        .clk   (scl),
        .rst_n (rst_n_reg),
        .d     ({write_inhibit, chip_select_pin_high, chip_select_pin_low, write_busy}),
        .q_reg (strap_s)
    );
    assign {wp_s, cs_s, busy_s} = strap_s;

    assign rx_byte   = {shift_reg[6:0], sda_i};
    assign sel       = rx_byte;
    assign byte_end  = bit_cnt_reg == `SEC_LAST_BIT;
    assign ack_slot  = bit_cnt_reg == `SEC_ACK_BIT;
    assign page_next = page_inc(addr_reg);
    assign rd_load   = ack_slot && st_reg == SEC_RDAT && (rd_first_reg || !sda_i);

    always_comb begin
        sel_ok = (sel.kind == `SEC_TYPE_MEM || sel.kind == `SEC_TYPE_ID)
                 && sel.cs == cs_s && !busy_s;
        mem_wr = !is_id_reg && !wp_s;
        id_wr  = is_id_reg && !id_lock_select_bit_reg && !lock_reg && !wp_s;
        lock_identification_command = is_id_reg && id_lock_select_bit_reg;
    end

    // frame state, cleared at every start
    always_ff @(posedge scl or posedge frame_clr_reg) begin
        if (frame_clr_reg) begin
            st_reg                 <= SEC_SEL;
            bit_cnt_reg            <= 4'h0;
            shift_reg              <= 8'h00;
            ack_reg                <= 1'b0;
            rd_first_reg           <= 1'b0;
            rd_tx_reg              <= 1'b0;
            is_id_reg              <= 1'b0;
            id_lock_select_bit_reg <= 1'b0;
            hi_reg                 <= 9'h000;
            wr_seen_reg            <= 1'b0;
        end else if (!ack_slot) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (byte_end) begin
                unique case (st_reg)
                    SEC_SEL: begin
                        if (sel_ok) begin
                            ack_reg      <= 1'b1;
                            is_id_reg    <= sel.kind == `SEC_TYPE_ID;
                            st_reg       <= sel.rd ? SEC_RDAT : SEC_AHI;
                            rd_first_reg <= sel.rd;
                            hi_reg[8]    <= sel.top_address_bit;
                        end else begin
                            st_reg <= SEC_IGN;
                        end
                    end
                    SEC_AHI: begin
                        ack_reg                <= 1'b1;
                        hi_reg[7:0]            <= rx_byte;
                        id_lock_select_bit_reg <= rx_byte[`SEC_HI_LOCK_BIT];
                        st_reg                 <= SEC_ALO;
                    end
                    SEC_ALO: begin
                        ack_reg <= 1'b1;
                        st_reg  <= SEC_WDAT;
                    end
                    SEC_WDAT: begin
                        if (mem_wr || id_wr || lock_identification_command) begin
                            ack_reg     <= 1'b1;
                            wr_seen_reg <= 1'b1;
                        end else begin
                            st_reg <= SEC_IGN;
                        end
                    end
                    SEC_RDAT, SEC_IGN: begin
                    end
                endcase
            end
        end else begin
            bit_cnt_reg <= 4'h0;
            ack_reg     <= 1'b0;
            if (st_reg == SEC_RDAT) begin
                rd_first_reg <= 1'b0;
                if (rd_load) begin
                    rd_tx_reg <= 1'b1;
                end else begin
                    rd_tx_reg <= 1'b0;
                    st_reg    <= SEC_IGN;
                end
            end
        end
    end

    // address counter, read data and lock flag survive frames
    always_ff @(posedge scl or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            addr_reg <= 17'h0_0000;
            tx_reg   <= 8'h00;
            lock_reg <= 1'b0;
        end else begin
            if (byte_end && st_reg == SEC_ALO) begin
                addr_reg <= {hi_reg, rx_byte};
            end else if (byte_end && st_reg == SEC_WDAT && (mem_wr || id_wr)) begin
                addr_reg <= page_next;
            end else if (rd_load) begin
                tx_reg   <= is_id_reg ? id_mem[addr_reg[7:0]] : mem[addr_reg];
                addr_reg <= is_id_reg ? page_next : addr_reg + 17'h0_0001;
            end
            if (byte_end && st_reg == SEC_WDAT && lock_identification_command
                && !wp_s && rx_byte[`SEC_LOCK_DATA_BIT]) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // storage is written as each byte arrives; the timer only models busy
    always_ff @(posedge scl) begin
        if (byte_end && st_reg == SEC_WDAT && mem_wr) begin
            mem[addr_reg] <= rx_byte;
        end
        if (byte_end && st_reg == SEC_WDAT && id_wr) begin
            id_mem[addr_reg[7:0]] <= rx_byte;
        end
    end

    // ==========================================================
    // sda driver: changes only while scl is low
    always_ff @(negedge scl or posedge frame_clr_reg) begin
        if (frame_clr_reg) begin
            oe_n_reg <= 1'b1;
        end else if (ack_reg) begin
            oe_n_reg <= 1'b0;
        end else if (rd_tx_reg && !ack_slot) begin
            oe_n_reg <= tx_reg[~bit_cnt_reg[2:0]];
        end else begin
            oe_n_reg <= 1'b1;
        end
    end

    assign sda_o     = 1'b0;
    assign sda_oe_n  = oe_n_reg;
    assign id_locked = lock_reg;

    // ==========================================================
    // checks
    chk_sel_mismatch : assert property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_SEL && sel.cs != cs_s |=> !ack_reg && st_reg == SEC_IGN)
        else $error("select with foreign chip bits was acknowledged");

    chk_busy_refuse : assert property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_SEL && busy_s |=> !ack_reg ##1 st_reg == SEC_IGN)
        else $error("select acknowledged while programming");

    chk_sel_accept : assert property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_SEL && sel_ok && sel.rd |=> ack_reg ##1 rd_tx_reg)
        else $error("read select not acknowledged or no data followed");

    chk_page_wrap : assert property (@(posedge scl) disable iff (!rst_n_reg)
        byte_end && st_reg == SEC_WDAT && mem_wr |=> addr_reg == $past(page_next))
        else $error("write address left its page");

    chk_locked_nack : assert property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_WDAT && is_id_reg && !id_lock_select_bit_reg && lock_reg
        |=> !ack_reg && st_reg == SEC_IGN)
        else $error("locked id page data byte acknowledged");

    chk_protect_nack : assert property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_WDAT && !is_id_reg && wp_s |=> !ack_reg)
        else $error("array write accepted while inhibited");

    chk_lock_sticky : assert property (@(posedge scl) disable iff (!rst_n_reg)
        lock_reg |=> lock_reg)
        else $error("lock flag cleared");

    chk_read_roll : assert property (@(posedge scl) disable iff (!rst_n_reg)
        rd_load && !is_id_reg && addr_reg == `SEC_ADDR_LAST |=> addr_reg == 17'h0_0000)
        else $error("read counter did not roll over");

    chk_master_nack : assert property (@(posedge scl) disable iff (frame_clr_reg)
        ack_slot && st_reg == SEC_RDAT && !rd_first_reg && sda_i
        |=> !rd_tx_reg && st_reg == SEC_IGN)
        else $error("read continued after controller nack");

    cov_read_select : cover property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_SEL && sel_ok && sel.rd);
    cov_page_wrap : cover property (@(posedge scl) disable iff (frame_clr_reg)
        byte_end && st_reg == SEC_WDAT && mem_wr && addr_reg[7:0] == 8'hff);
    cov_lock_set : cover property (@(posedge scl) disable iff (!rst_n_reg)
        $rose(lock_reg));
    cov_seq_read : cover property (@(posedge scl) disable iff (frame_clr_reg)
        ack_slot && st_reg == SEC_RDAT && !rd_first_reg && !sda_i);
endmodule : sec_engine
`default_nettype wire

// ==== verif/sec_ctl_model.sv ====
// two-wire bus controller model driving scl and pulling sda
`timescale 1ns/1ps
`default_nettype none
module sec_ctl_model (
    // bus wires, sda_low pulls the open-drain line down
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // one bit slot of 160 ns; scl moves inside frames and in the one slot the bench runs after reset
    task automatic slot(input logic b, output logic r);
        #40 sda_low = ~b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask : slot
    // from idle or, with scl low, as a repeated start
    task automatic start();
        if (!scl) begin
            #40 sda_low = 1'b0;
            #40 scl = 1'b1;
        end
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask : start
    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask : stop
    // ack is 1 when the target pulled the ninth slot low
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) slot(d[i], r);
        slot(1'b1, r);
        ack = ~r;
    endtask : wbyte
    // last byte gets no acknowledge so the target lets go
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, r);
            d[i] = r;
        end
        slot(last, r);
    endtask : rbyte
endmodule : sec_ctl_model
`default_nettype wire

// ==== verif/test_serial_eeprom_command_engine.sv ====
// self-checking bench of the serial eeprom command engine
`timescale 1ns/1ps
`default_nettype none
`include "sec_consts.svh"
module test_serial_eeprom_command_engine;
    // short programming time keeps polling inside one busy window
    localparam int WR = 1000;
    localparam logic [3:0] MEM = `SEC_TYPE_MEM;
    localparam logic [3:0] IDP = `SEC_TYPE_ID;
    logic        ref_clk, rstn, inh, sda_o, sda_oe_n, busy, locked, scl, sda_low, sda, lck, b;
    logic [1:0]  cs;
    logic [16:0] ctr, a;
    logic [7:0]  mem [int];
    logic [7:0]  idp [int];
    int          n_errors, n_compared;

    sec_engine #(.WR_CYCLES(WR)) uut (.ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .chip_select_pin_low(cs[0]),
        .chip_select_pin_high(cs[1]), .write_inhibit(inh), .write_busy(busy), .id_locked(locked));
    sec_ctl_model ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
    // pull-up wins unless someone pulls low
    assign sda = ~sda_low & (sda_oe_n | sda_o);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ==========
    // checks
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // always lands just after a ref_clk edge so scl never moves on one
    task automatic wait_idle();
        int i;
        for (i = 0; i < 4 * WR; i++) begin
            @(posedge ref_clk);
            if (busy === 1'b0) break;
        end
        #1;
        if (i == 4 * WR) begin
            n_errors++;
            end_of_test();
        end
    endtask : wait_idle
    // ==========
    // frames
    task automatic sel(input logic [3:0] k, input logic t, input logic r, input logic [1:0] c,
                       input logic exp);
        logic ak;
        ctl.start();
        ctl.wbyte({k, c, t, r}, ak);
        chk_bit("select ack", exp, ak);
    endtask : sel
    task automatic wr(input logic [3:0] k, input logic [16:0] ad, input int n);
        logic ak, ok, any;
        logic [7:0] d;
        logic [16:0] p;
        any = 1'b0;
        p = ad;
        sel(k, ad[16], 1'b0, cs, 1'b1);
        ctl.wbyte(ad[15:8], ak);
        chk_bit("high addr ack", 1'b1, ak);
        ctl.wbyte(ad[7:0], ak);
        chk_bit("low addr ack", 1'b1, ak);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (k == IDP && ad[10]) d[1] = 1'b1;
            ok = (k == MEM) ? !inh : (ad[10] || !(inh || lck));
            ctl.wbyte(d, ak);
            chk_bit("data ack", ok, ak);
            if (!ok) break;
            any = 1'b1;
            if (k == MEM) mem[p] = d;
            else if (!ad[10]) idp[p[7:0]] = d;
            else if (!inh) lck = 1'b1;
            p[7:0] = p[7:0] + 8'h01;
        end
        if (k == MEM && any) ctr = p;
        ctl.stop();
        chk_bit("busy after stop", any, busy);
        if (any) begin
            sel(MEM, ad[16], 1'b0, cs, 1'b0);
            ctl.stop();
            wait_idle();
        end
    endtask : wr
    task automatic rd(input logic [3:0] k, input logic rnd, input logic [16:0] ad, input int n);
        logic ak;
        logic [7:0] d;
        if (rnd) begin
            sel(k, ad[16], 1'b0, cs, 1'b1);
            ctl.wbyte(ad[15:8], ak);
            ctl.wbyte(ad[7:0], ak);
            chk_bit("dummy addr ack", 1'b1, ak);
            ctr = ad;
        end
        sel(k, ctr[16], 1'b1, cs, 1'b1);
        for (int i = 0; i < n; i++) begin
            ctl.rbyte(i == n - 1, d);
            chk_byte("read data", (k == MEM) ? mem[ctr] : idp[ctr[7:0]], d);
            if (k == MEM) ctr = ctr + 17'h0_0001;
            else ctr[7:0] = ctr[7:0] + 8'h01;
        end
        ctl.stop();
    endtask : rd
    // ==========
    // sequence
    initial begin
        void'($urandom(97));
        rstn = 1'b0;
        inh = 1'b0;
        lck = 1'b0;
        cs = 2'($urandom);
        n_errors = 0;
        n_compared = 0;
        repeat (2) @(posedge ref_clk);
        #1 rstn = 1'b1;
        chk_bit("busy at reset", 1'b0, busy);
        chk_bit("lock at reset", 1'b0, locked);
        chk_bit("oe_n at reset", 1'b1, sda_oe_n);
        repeat (4) @(posedge ref_clk);
        #1 ctl.slot(1'b1, b);
        a = {9'($urandom), 8'hfe};
        wr(MEM, a, 4);
        rd(MEM, 1'b1, {a[16:8], 8'h00}, 1);
        rd(MEM, 1'b0, ctr, 1);
        rd(MEM, 1'b1, a, 2);
        sel(MEM, 1'b0, 1'b0, ~cs, 1'b0);
        ctl.stop();
        sel(4'h5, 1'b0, 1'b1, cs, 1'b0);
        ctl.stop();
        wr(MEM, 17'h1_ffff, 1);
        wr(MEM, 17'h0_0000, 1);
        rd(MEM, 1'b1, 17'h1_ffff, 2);
        inh = 1'b1;
        wr(MEM, {a[16:8], 8'h00}, 1);
        inh = 1'b0;
        rd(MEM, 1'b1, {a[16:8], 8'h00}, 1);
        // low byte kept below 0x80 so id reads of three bytes stay inside the page
        a = 17'($urandom) & 17'h1_fb7f;
        wr(IDP, a, 3);
        wr(IDP, {a[16:8], 8'hff}, 3);
        rd(IDP, 1'b1, 17'($urandom) & 17'h1_ff00, 2);
        wr(IDP, a, 1);
        wr(IDP, a | 17'h0_0400, 1);
        chk_bit("lock flag", 1'b1, locked);
        wr(IDP, a, 2);
        rd(IDP, 1'b1, a, 3);
        wr(IDP, a | 17'h0_0400, 1);
        chk_bit("lock kept", 1'b1, locked);
        end_of_test();
    end
endmodule : test_serial_eeprom_command_engine
`default_nettype wire
